// File: common/phy_ctl_pkg.sv
// Package for the management control and indicator block of a 10/100 PHY.
// Assumes a Wishbone classic slave with 32-bit data, one register per word.
package phy_ctl_pkg;

   // ==========================================================
   // Register indices (printed offsets) and byte addresses
   // ==========================================================
   localparam logic [4:0]  IDX_BASIC_CONTROL     = 5'h00;
   localparam logic [4:0]  IDX_BASIC_STATUS      = 5'h01;
   localparam logic [4:0]  IDX_IDENTIFIER_HIGH   = 5'h02;
   localparam logic [4:0]  IDX_IDENTIFIER_LOW    = 5'h03;
   localparam logic [4:0]  IDX_NEG_ADVERTISE     = 5'h04;
   localparam logic [4:0]  IDX_PARTNER_ABILITY   = 5'h05;
   localparam logic [4:0]  IDX_NEG_EXPANSION     = 5'h06;
   localparam logic [4:0]  IDX_NEXT_PAGE_TX      = 5'h07;
   localparam logic [4:0]  IDX_PARTNER_NEXT_PAGE = 5'h08;
   localparam logic [4:0]  IDX_RESERVED_FIRST    = 5'h09;
   localparam logic [4:0]  IDX_RESERVED_LAST     = 5'h0f;
   localparam logic [4:0]  IDX_INDICATOR_CONFIG  = 5'h14;
   localparam logic [4:0]  IDX_STRAP_STATUS      = 5'h15;
   localparam int          ADDR_LSB              = 2;

   // ==========================================================
   // Control register field positions
   // ==========================================================
   localparam int          CTL_RESET_BIT         = 15;
   localparam int          CTL_LOOPBACK_BIT      = 14;
   localparam int          CTL_SPEED_BIT         = 13;
   localparam int          CTL_AN_ENABLE_BIT     = 12;
   localparam int          CTL_LOW_POWER_BIT     = 11;
   localparam int          CTL_ISOLATE_BIT       = 10;
   localparam int          CTL_AN_RESTART_BIT    = 9;
   localparam int          CTL_DUPLEX_BIT        = 8;
   localparam int          CTL_COL_TEST_BIT      = 7;
   localparam logic [15:0] CTL_WRITABLE_MASK     = 16'hff80;
   localparam logic [15:0] CTL_RESET_VALUE       = 16'h3100;

   // ==========================================================
   // Other reset values and constants
   // ==========================================================
   localparam logic [15:0] STATUS_FIXED_VALUE    = 16'h7809;
   localparam logic [15:0] ADVERTISE_RESET_VALUE = 16'h01e1;
   localparam logic [15:0] NEXT_PAGE_RESET_VALUE = 16'h2001;
   localparam logic [15:0] INDICATOR_RESET_VALUE = 16'h4321;
   localparam logic [15:0] ID_HIGH_VALUE         = 16'h0000; // Arbitrary identity value
   localparam logic [15:0] ID_LOW_VALUE          = 16'h0010; // Arbitrary identity value
   localparam int          PIN_COUNT             = 5;
   localparam int          SEL_WIDTH             = 3;
   localparam int          SW_RESET_CYCLES       = 4;

   // Indicator source selections, one 3-bit field per pin
   typedef enum logic [2:0] {
      SRC_LINK     = 3'h0,
      SRC_ACTIVITY = 3'h1,
      SRC_TX       = 3'h2,
      SRC_RX       = 3'h3,
      SRC_COL      = 3'h4,
      SRC_SPEED    = 3'h5,
      SRC_DUPLEX   = 3'h6,
      SRC_OFF      = 3'h7
   } indicator_src_t;

   // Live link events feeding the indicators
   typedef struct packed {
      logic link;
      logic activity;
      logic tx;
      logic rx;
      logic col;
   } link_events_t;

   // Control outputs toward the PHY core
   typedef struct packed {
      logic soft_reset;
      logic loopback;
      logic speed_100;
      logic an_enable;
      logic low_power;
      logic isolate;
      logic an_restart;
      logic full_duplex;
      logic col_test;
   } phy_ctrl_t;

endpackage

// File: core/indicator_pins.sv
// Five strap/indicator pins: sample on hard reset exit, then drive status.
// Assumes link events are synchronous to clk_i.
`timescale 1ns/100ps
module indicator_pins #(
   parameter int N = phy_ctl_pkg::PIN_COUNT
) (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic [N-1:0]               pin_i,
   input  wire logic [3*N-1:0]             sel_i,
   input  wire phy_ctl_pkg::link_events_t  ev_i,
   input  wire logic                       speed_i,
   input  wire logic                       duplex_i,
   output logic      [N-1:0]               pin_o,
   output logic      [N-1:0]               pin_oe_o,
   output logic      [N-1:0]               strap_o
);

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      logic         in_reset; // Hard reset seen, sample due
      logic [N-1:0] strap;    // Levels latched at reset exit
      logic [N-1:0] drive;    // Pin output levels
      logic [N-1:0] oe;       // Pin output enables
   } pin_state_t;

   pin_state_t s_q;
   pin_state_t s_d;
   logic [N-1:0] active;      // Selected source asserted

   // Per-pin source selection
   genvar g;
   for (g = 0; g < N; g++) begin : g_pin
      always_comb begin
         case (phy_ctl_pkg::indicator_src_t'(sel_i[3*g +: 3]))
            phy_ctl_pkg::SRC_LINK:     active[g] = ev_i.link;
            phy_ctl_pkg::SRC_ACTIVITY: active[g] = ev_i.activity;
            phy_ctl_pkg::SRC_TX:       active[g] = ev_i.tx;
            phy_ctl_pkg::SRC_RX:       active[g] = ev_i.rx;
            phy_ctl_pkg::SRC_COL:      active[g] = ev_i.col;
            phy_ctl_pkg::SRC_SPEED:    active[g] = speed_i;
            phy_ctl_pkg::SRC_DUPLEX:   active[g] = duplex_i;
            default:                   active[g] = 1'b0;
         endcase
      end
   end

   // Next state: inputs during hard reset, sample on exit, then drive
   always_comb begin
      s_d = s_q;
      if (s_q.in_reset) begin
         s_d.strap    = pin_i;                      // R03
         s_d.in_reset = 1'b0;
      end
      s_d.oe    = {N{1'b1}};                         // R03 R04
      s_d.drive = s_d.strap ^ active;                // R05 R02
   end

   // Registers; hard reset floats pins, soft reset never reaches here
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q.in_reset <= 1'b1;                       // R03
         s_q.strap    <= '0;
         s_q.drive    <= '0;
         s_q.oe       <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign pin_o    = s_q.drive;
   assign pin_oe_o = s_q.oe;
   assign strap_o  = s_q.strap;

endmodule

// File: core/phy_control_and_led_status.sv
// Management register bank and indicator pins of a 10/100 PHY.
// Assumes a Wishbone classic master on clk_i (25 MHz) and synchronous inputs.
// Functional notes
// R01 - Five indicator pins configured by register 20
// R02 - Each pin selects link, activity, tx, rx, col, speed, duplex
// R03 - Pins sample at hard reset exit, then drive
// R04 - Software reset keeps straps, pins stay outputs
// R05 - Asserted output level is inverse of strap
// R06 - Address bits come from first two straps
// R07 - Standard map 0..8, reserved 9..15, vendor 16..31
// R08 - Reset and restart bits self clear; zero ignored
// R09 - Speed and negotiation enable default to one
// R10 - Duplex defaults one; loopback, power, isolate, test zero
// R11 - Control bits 6..0 read zero, writes ignored
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/100ps
module phy_control_and_led_status #(
   parameter logic [15:0] ID_HIGH = phy_ctl_pkg::ID_HIGH_VALUE, // Arbitrary value
   parameter logic [15:0] ID_LOW  = phy_ctl_pkg::ID_LOW_VALUE   // Arbitrary value
) (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   // Wishbone classic slave
   input  wire logic                       cyc_i,
   input  wire logic                       stb_i,
   input  wire logic                       we_i,
   input  wire logic [6:0]                 adr_i,
   input  wire logic [3:0]                 sel_i,
   input  wire logic [31:0]                dat_i,
   output logic      [31:0]                dat_o,
   output logic                            ack_o,
   // Indicator pins
   input  wire logic [4:0]                 ind_pin_i,
   output logic      [4:0]                 ind_pin_o,
   output logic      [4:0]                 ind_pin_oe_o,
   // PHY core status in, control out
   input  wire phy_ctl_pkg::link_events_t  events_i,
   input  wire logic [15:0]                partner_ability_i,
   input  wire logic [15:0]                expansion_i,
   input  wire logic [15:0]                partner_next_page_i,
   output phy_ctl_pkg::phy_ctrl_t          ctrl_o,
   output logic      [1:0]                 mgmt_addr_o
);

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      logic [15:0]             control;    // Control register stored bits
      logic [15:0]             advertise;  // Advertisement register
      logic [15:0]             next_page;  // Next page transmit register
      logic [15:0]             ind_cfg;    // Indicator selection register
      logic [31:0]             rdata;      // Bus read data
      logic                    ack;        // Bus acknowledge
      logic [2:0]              rst_cnt;    // Soft reset pulse counter
      logic                    restart;    // Restart pulse
      phy_ctl_pkg::phy_ctrl_t  ctrl;       // Registered control outputs
   } bank_t;

   bank_t s_q;
   bank_t s_d;

   logic [4:0]  idx;        // Word index from byte address
   logic        req;        // New bus request
   logic [15:0] wmask;      // Byte-lane mask of the low half word
   logic [15:0] rd_mux;     // Read data before register
   logic [4:0]  strap;      // Latched strap levels

   assign idx   = adr_i[6:phy_ctl_pkg::ADDR_LSB];
   assign req   = cyc_i && stb_i && !s_q.ack;
   assign wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};

   // ==========================================================
   // Indicator pins
   // ==========================================================
   indicator_pins #(
      .N        (phy_ctl_pkg::PIN_COUNT)
   ) u_pins (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .pin_i    (ind_pin_i),
      .sel_i    (s_q.ind_cfg[14:0]),                // R01
      .ev_i     (events_i),
      .speed_i  (s_q.control[phy_ctl_pkg::CTL_SPEED_BIT]),
      .duplex_i (s_q.control[phy_ctl_pkg::CTL_DUPLEX_BIT]),
      .pin_o    (ind_pin_o),
      .pin_oe_o (ind_pin_oe_o),
      .strap_o  (strap)
   );

   // ==========================================================
   // Read multiplexer
   // ==========================================================
   // Decodes the word index into register contents
   always_comb begin
      case (idx)                                    // R07
         phy_ctl_pkg::IDX_BASIC_CONTROL:
            rd_mux = s_q.control & phy_ctl_pkg::CTL_WRITABLE_MASK; // R11
         phy_ctl_pkg::IDX_BASIC_STATUS:
            rd_mux = phy_ctl_pkg::STATUS_FIXED_VALUE | {13'h0000, events_i.link, 2'h0};
         phy_ctl_pkg::IDX_IDENTIFIER_HIGH:   rd_mux = ID_HIGH;
         phy_ctl_pkg::IDX_IDENTIFIER_LOW:    rd_mux = ID_LOW;
         phy_ctl_pkg::IDX_NEG_ADVERTISE:     rd_mux = s_q.advertise;
         phy_ctl_pkg::IDX_PARTNER_ABILITY:   rd_mux = partner_ability_i;
         phy_ctl_pkg::IDX_NEG_EXPANSION:     rd_mux = expansion_i;
         phy_ctl_pkg::IDX_NEXT_PAGE_TX:      rd_mux = s_q.next_page;
         phy_ctl_pkg::IDX_PARTNER_NEXT_PAGE: rd_mux = partner_next_page_i;
         phy_ctl_pkg::IDX_INDICATOR_CONFIG:  rd_mux = s_q.ind_cfg;
         phy_ctl_pkg::IDX_STRAP_STATUS:      rd_mux = {11'h000, strap};
         default:                            rd_mux = 16'h0000; // Reserved reads zero
      endcase
   end

   // ==========================================================
   // Next-state logic
   // ==========================================================
   always_comb begin
      s_d         = s_q;
      s_d.ack     = req;                            // Answer one cycle after request
      s_d.restart = 1'b0;
      // Soft reset pulse runs down, then returns to defaults
      if (s_q.rst_cnt != 3'h0) begin
         s_d.rst_cnt = s_q.rst_cnt - 3'h1;
         if (s_q.rst_cnt == 3'h1) begin
            s_d.control   = phy_ctl_pkg::CTL_RESET_VALUE; // R08 R04
            s_d.advertise = phy_ctl_pkg::ADVERTISE_RESET_VALUE;
            s_d.next_page = phy_ctl_pkg::NEXT_PAGE_RESET_VALUE;
         end
      end
      if (req) begin
         s_d.rdata = {16'h0000, rd_mux};
         if (we_i) begin
            case (idx)
               phy_ctl_pkg::IDX_BASIC_CONTROL: begin
                  // Only bits 15..7 store; reset and restart never stored as one
                  s_d.control = (s_q.control & ~(wmask & phy_ctl_pkg::CTL_WRITABLE_MASK))
                              | (dat_i[15:0] & wmask & phy_ctl_pkg::CTL_WRITABLE_MASK); // R11
                  s_d.control[phy_ctl_pkg::CTL_RESET_BIT]      = 1'b0; // R08
                  s_d.control[phy_ctl_pkg::CTL_AN_RESTART_BIT] = 1'b0; // R08
                  if (sel_i[1] && dat_i[phy_ctl_pkg::CTL_AN_RESTART_BIT]) begin
                     s_d.restart = 1'b1;            // R08
                  end
                  if (sel_i[1] && dat_i[phy_ctl_pkg::CTL_RESET_BIT]) begin
                     s_d.rst_cnt = 3'(phy_ctl_pkg::SW_RESET_CYCLES); // R08
                  end
               end
               phy_ctl_pkg::IDX_NEG_ADVERTISE:
                  s_d.advertise = (s_q.advertise & ~wmask) | (dat_i[15:0] & wmask);
               phy_ctl_pkg::IDX_NEXT_PAGE_TX:
                  s_d.next_page = (s_q.next_page & ~wmask) | (dat_i[15:0] & wmask);
               phy_ctl_pkg::IDX_INDICATOR_CONFIG:
                  s_d.ind_cfg = (s_q.ind_cfg & ~wmask) | (dat_i[15:0] & wmask); // R01
               default: begin
                  // Read-only or reserved: write ignored
               end
            endcase
         end
      end
      // Control outputs from stored fields
      s_d.ctrl.soft_reset  = (s_d.rst_cnt != 3'h0);
      s_d.ctrl.loopback    = s_d.control[phy_ctl_pkg::CTL_LOOPBACK_BIT];  // R10
      s_d.ctrl.speed_100   = s_d.control[phy_ctl_pkg::CTL_SPEED_BIT];     // R09
      s_d.ctrl.an_enable   = s_d.control[phy_ctl_pkg::CTL_AN_ENABLE_BIT]; // R09
      s_d.ctrl.low_power   = s_d.control[phy_ctl_pkg::CTL_LOW_POWER_BIT]; // R10
      s_d.ctrl.isolate     = s_d.control[phy_ctl_pkg::CTL_ISOLATE_BIT];   // R10
      s_d.ctrl.an_restart  = s_d.restart;
      s_d.ctrl.full_duplex = s_d.control[phy_ctl_pkg::CTL_DUPLEX_BIT];    // R10
      s_d.ctrl.col_test    = s_d.control[phy_ctl_pkg::CTL_COL_TEST_BIT];  // R10
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q.control          <= phy_ctl_pkg::CTL_RESET_VALUE; // R09 R10
         s_q.advertise        <= phy_ctl_pkg::ADVERTISE_RESET_VALUE;
         s_q.next_page        <= phy_ctl_pkg::NEXT_PAGE_RESET_VALUE;
         s_q.ind_cfg          <= phy_ctl_pkg::INDICATOR_RESET_VALUE;
         s_q.rdata            <= 32'h00000000;
         s_q.ack              <= 1'b0;
         s_q.rst_cnt          <= 3'h0;
         s_q.restart          <= 1'b0;
         s_q.ctrl.soft_reset  <= 1'b0;
         s_q.ctrl.loopback    <= 1'b0;
         s_q.ctrl.speed_100   <= 1'b1;
         s_q.ctrl.an_enable   <= 1'b1;
         s_q.ctrl.low_power   <= 1'b0;
         s_q.ctrl.isolate     <= 1'b0;
         s_q.ctrl.an_restart  <= 1'b0;
         s_q.ctrl.full_duplex <= 1'b1;
         s_q.ctrl.col_test    <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flip-flops
   assign dat_o       = s_q.rdata;
   assign ack_o       = s_q.ack;
   assign ctrl_o      = s_q.ctrl;
   assign mgmt_addr_o = strap[1:0];                 // R06

endmodule

// File: bench/phy_ctl_asserts.sv
// Port checks for the PHY control and indicator block.
// Assumes it is bound onto phy_control_and_led_status, one clock domain.
`timescale 1ns/100ps
module phy_ctl_asserts (
   input wire logic                   clk_i,
   input wire logic                   rst_i,
   input wire logic                   cyc_i,
   input wire logic                   stb_i,
   input wire logic                   we_i,
   input wire logic [6:0]             adr_i,
   input wire logic [3:0]             sel_i,
   input wire logic [31:0]            dat_i,
   input wire logic [31:0]            dat_o,
   input wire logic                   ack_o,
   input wire logic [4:0]             ind_pin_i,
   input wire logic [4:0]             ind_pin_oe_o,
   input wire phy_ctl_pkg::phy_ctrl_t ctrl_o,
   input wire logic [1:0]             mgmt_addr_o
);
   // ==========================================
   // Clocking and bus steps
   // ==========================================
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Request to the control register taken
   sequence ctl_taken;
      cyc_i && stb_i && !ack_o && adr_i[6:2] == 5'h00;
   endsequence
   // Control write with the reset bit set
   sequence sw_reset_wr;
      ctl_taken ##0 (we_i && sel_i[1] && dat_i[15]);
   endsequence
   // Control write with the restart bit set
   sequence restart_wr;
      ctl_taken ##0 (we_i && sel_i[1] && dat_i[9]);
   endsequence
   // ==========================================
   // Assertions
   // ==========================================
   AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack missing one cycle after request");
   AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   AST_SW_RESET: assert property (sw_reset_wr |=>
      ctrl_o.soft_reset[*4] ##1 !ctrl_o.soft_reset)
      else $error("soft reset pulse length wrong");
   AST_RESTART: assert property (restart_wr |=> ctrl_o.an_restart ##1 !ctrl_o.an_restart)
      else $error("restart pulse wrong");
   AST_CTL_READ: assert property (ctl_taken ##0 !we_i |=>
      ack_o && dat_o[6:0] == 7'h00 && !dat_o[15] && !dat_o[9])
      else $error("control read shows reserved or self clearing bits");
   AST_PIN_TURN: assert property ($fell(rst_i) |->
      ind_pin_oe_o == 5'h00 ##1 ind_pin_oe_o == 5'h1f)
      else $error("pins did not turn to outputs after reset exit");
   AST_SW_KEEP: assert property (ctrl_o.soft_reset |->
      ind_pin_oe_o == 5'h1f ##1 $stable(mgmt_addr_o))
      else $error("soft reset disturbed pins or address");
   AST_ADDR: assert property ($fell(rst_i) |=> mgmt_addr_o == $past(ind_pin_i[1:0]))
      else $error("address not taken from straps");
endmodule
bind phy_control_and_led_status phy_ctl_asserts chk_u (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
   .dat_o(dat_o), .ack_o(ack_o), .ind_pin_i(ind_pin_i), .ind_pin_oe_o(ind_pin_oe_o),
   .ctrl_o(ctrl_o), .mgmt_addr_o(mgmt_addr_o));

// File: bench/strap_board.sv
// Board around the indicator pins: strap resistors and LEDs.
// Assumes the block drives a pin only while its enable is high.
`timescale 1ns/100ps
module strap_board #(
   parameter logic [4:0] PULL = 5'h16 // Resistor levels seen while undriven
) (
   input  wire logic [4:0] drive_i,
   input  wire logic [4:0] oe_i,
   output logic      [4:0] level_o
);
   // Wire level: driven value, else the strap resistor
   assign level_o = (oe_i & drive_i) | (~oe_i & PULL);
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the PHY control and indicator block.
// Assumes the design package is compiled first; bus is Wishbone classic.
`timescale 1ns/100ps
module tb_top;
   localparam logic [4:0] PULL = 5'h16; // Strap levels on the board
   logic                       clk_i = 1'b0;
   logic                       rst_i = 1'b1;
   logic                       cyc_i = 1'b0;
   logic                       stb_i = 1'b0;
   logic                       we_i = 1'b0;
   logic [6:0]                 adr_i = 7'h00;
   logic [3:0]                 sel_i = 4'h0;
   logic [31:0]                dat_i = 32'h0;
   logic [31:0]                dat_o;
   logic                       ack_o;
   logic [4:0]                 ind_pin_i;
   logic [4:0]                 ind_pin_o;
   logic [4:0]                 ind_pin_oe_o;
   phy_ctl_pkg::link_events_t  events_i = '0;
   phy_ctl_pkg::phy_ctrl_t     ctrl_o;
   logic [1:0]                 mgmt_addr_o;
   int                         fail_count = 0;
   int                         check_count = 0;
   // Clock, 40 ns period
   always #20 clk_i = ~clk_i;
   phy_control_and_led_status dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .ind_pin_i(ind_pin_i), .ind_pin_o(ind_pin_o),
      .ind_pin_oe_o(ind_pin_oe_o), .events_i(events_i), .partner_ability_i(16'h05e1),
      .expansion_i(16'h0003), .partner_next_page_i(16'h4001), .ctrl_o(ctrl_o),
      .mgmt_addr_o(mgmt_addr_o));
   strap_board #(.PULL(PULL)) brd_u (.drive_i(ind_pin_o), .oe_i(ind_pin_oe_o),
      .level_o(ind_pin_i));
   // ==========================================
   // Shared tasks
   // ==========================================
   // Compare and report
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One classic cycle, held until ack
   task automatic bus(input logic we, input logic [4:0] idx, input logic [15:0] wd,
                      output logic [15:0] rd);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= we;
      adr_i <= {idx, 2'b00};
      sel_i <= 4'h3;
      dat_i <= {16'h0000, wd};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1);
      // Ack stands in the cycle after the taking edge; the watchdog ends a hang
      chk("ack wait", 16'h0002, 16'(n));
      rd = dat_o[15:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   // Register write
   task automatic wr(input logic [4:0] idx, input logic [15:0] wd);
      logic [15:0] rd;
      bus(1'b1, idx, wd, rd);
   endtask
   // Register read and compare
   task automatic rdc(input logic [4:0] idx, input logic [15:0] exp);
      logic [15:0] rd;
      bus(1'b0, idx, 16'h0000, rd);
      chk($sformatf("reg %h", idx), exp, rd);
   endtask
   // ==========================================
   // Scenarios
   // ==========================================
   // Map and reset values, reserved and vendor holes
   task automatic t_map;
      rdc(5'h00, 16'h3100);
      rdc(5'h01, 16'h7809);
      rdc(5'h02, phy_ctl_pkg::ID_HIGH_VALUE);
      rdc(5'h03, phy_ctl_pkg::ID_LOW_VALUE);
      rdc(5'h04, 16'h01e1);
      rdc(5'h05, 16'h05e1);
      rdc(5'h06, 16'h0003);
      rdc(5'h07, 16'h2001);
      rdc(5'h08, 16'h4001);
      rdc(5'h09, 16'h0000);
      rdc(5'h0f, 16'h0000);
      rdc(5'h10, 16'h0000);
      rdc(5'h14, 16'h4321);
      rdc(5'h15, {11'h000, PULL});
      chk("addr", {14'h0, PULL[1:0]}, {14'h0, mgmt_addr_o});
   endtask
   // Control fields, reserved bits, read-only places
   task automatic t_ctl;
      wr(5'h00, 16'h7dff);
      rdc(5'h00, 16'h7d80);
      chk("ctrl", 16'h00fb, {7'h00, ctrl_o});
      wr(5'h00, 16'h0000);
      rdc(5'h00, 16'h0000);
      chk("ctrl", 16'h0000, {7'h00, ctrl_o});
      wr(5'h00, 16'h3300);
      rdc(5'h00, 16'h3100);
      wr(5'h01, 16'h0000);
      rdc(5'h01, 16'h7809);
      wr(5'h09, 16'hffff);
      rdc(5'h09, 16'h0000);
   endtask
   // Soft reset keeps straps and indicator setup
   task automatic t_soft;
      wr(5'h14, 16'h0ffa);
      wr(5'h04, 16'h0000);
      wr(5'h00, 16'h8000);
      repeat (6) @(posedge clk_i);
      chk("oe", 16'h001f, {11'h000, ind_pin_oe_o});
      rdc(5'h00, 16'h3100);
      rdc(5'h04, 16'h01e1);
      rdc(5'h14, 16'h0ffa);
      rdc(5'h15, {11'h000, PULL});
   endtask
   // Drive a source on or off for an indicator code
   task automatic set_src(input int c, input logic on);
      if (c < 5) begin
         events_i <= on ? phy_ctl_pkg::link_events_t'(5'h10 >> c) : '0;
      end else begin
         wr(5'h00, on ? 16'h3100 : 16'h1000);
      end
      repeat (3) @(posedge clk_i);
   endtask
   // Every source code, both states, inverted polarity
   task automatic t_leds;
      logic [2:0] code;
      for (int c = 0; c < 8; c++) begin
         code = 3'(c);
         wr(5'h14, {1'b0, {5{code}}});
         set_src(c, 1'b1);
         chk($sformatf("pins on %0d", c), {11'h0, (c == 7) ? PULL : ~PULL},
             {11'h0, ind_pin_o});
         set_src(c, 1'b0);
         chk($sformatf("pins off %0d", c), {11'h0, PULL}, {11'h0, ind_pin_o});
         set_src(c, 1'b1);
      end
   endtask
   // ==========================================
   // Verdict and run
   // ==========================================
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_map;
      t_ctl;
      t_soft;
      t_leds;
      complete_run;
   end
   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      complete_run;
   end
endmodule
